/* File: sli_blink_gen.sv */
// Free-running square wave used for blinking lamps
`timescale 1ns/10ps
module sli_blink_gen #(
  parameter int unsigned HALF_CYCLES = sli_pkg::BLINK_HALF_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  output logic      blink_o
);
  import sli_pkg::*;

  logic [31:0] half_cnt;
  logic        wrap;

  assign wrap = (half_cnt == 32'(HALF_CYCLES - 1));

  // Half-period counter
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      half_cnt <= BLINK_CNT_RST;
    end else if (wrap) begin
      half_cnt <= BLINK_CNT_RST;
    end else begin
      half_cnt <= half_cnt + 32'h0000_0001;
    end
  end

  // Phase toggles once per half period
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      blink_o <= LAMP_RST;
    end else if (wrap) begin
      blink_o <= ~blink_o;
    end
  end

endmodule // sli_blink_gen

/* File: sli_lamp_watch.sv */
// Operator model that counts the lamp changes an observer would see
`timescale 1ns/10ps
module sli_lamp_watch (
  input  wire logic       sys_clk_i,
  input  wire logic       clear_i,
  input  wire logic       lamp_i,
  output logic      [7:0] toggles_o
);
  logic last;
  // A blinking lamp shows repeated changes, a steady one none
  always_ff @(posedge sys_clk_i) begin
    last <= lamp_i;
    if (clear_i) begin
      toggles_o <= 8'h00;
    end else if (lamp_i !== last) begin
      toggles_o <= toggles_o + 8'h01;
    end
  end
endmodule // sli_lamp_watch

/* File: sli_pkg.sv */
// Constants shared by the front-panel indicator lamp logic
//
// Overview of operation
// - The link lamp is lit only while the upstream transmitter is properly connected to our receiver.
// - A warning blinks the error lamp and leaves operation running.
// - An error lights the error lamp steadily and halts operation, and with neither present the lamp is dark.
// - A system error lights the alarm lamp and holds it until reset.
// - In the single-lamp variant each pulser lamp lights when both phases are on and goes dark when both are off.
// - In the two-lamp variant each phase of each of three pulsers drives its own lamp that follows that phase.
package sli_pkg;

  localparam int unsigned CLK_FREQ_HZ       = 100_000_000;
  localparam int unsigned BLINK_HALF_MS     = 250;
  localparam int unsigned BLINK_HALF_CYCLES = (CLK_FREQ_HZ / 1000) * BLINK_HALF_MS;
  localparam int unsigned PULSER_COUNT      = 3;
  localparam logic        LAMP_RST          = 1'b0;
  localparam logic        SYNC_RST          = 1'b0;
  localparam logic [31:0] BLINK_CNT_RST     = 32'h0000_0000;

  typedef enum logic {
    SLI_ONE_LAMP,
    SLI_TWO_LAMP
  } sli_variant_t;

endpackage

/* File: sli_status_led.sv */
// Front-panel indicator lamp drivers
`timescale 1ns/10ps
module sli_status_led #(
  parameter sli_pkg::sli_variant_t VARIANT     = sli_pkg::SLI_ONE_LAMP,
  parameter int unsigned           HALF_CYCLES = sli_pkg::BLINK_HALF_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  input  wire logic net_established_i,
  input  wire logic link_connected_i,
  input  wire logic warning_i,
  input  wire logic error_i,
  input  wire logic system_error_i,
  input  wire logic pulser_one_phase_a_i,
  input  wire logic pulser_one_phase_b_i,
  input  wire logic pulser_two_phase_a_i,
  input  wire logic pulser_two_phase_b_i,
  input  wire logic pulser_three_phase_a_i,
  input  wire logic pulser_three_phase_b_i,
  output logic      status_lamp_o,
  output logic      link_lamp_o,
  output logic      error_lamp_o,
  output logic      alarm_lamp_o,
  output logic      halt_o,
  output logic      pulser_one_lamp_o,
  output logic      pulser_two_lamp_o,
  output logic      pulser_three_lamp_o,
  output logic      pulser_one_phase_a_lamp_o,
  output logic      pulser_one_phase_b_lamp_o,
  output logic      pulser_two_phase_a_lamp_o,
  output logic      pulser_two_phase_b_lamp_o,
  output logic      pulser_three_phase_a_lamp_o,
  output logic      pulser_three_phase_b_lamp_o
);
  import sli_pkg::*;

  logic                    blink;
  logic                    rst_q;
  logic                    link_s1;
  logic                    link_s2;
  logic [PULSER_COUNT-1:0] pha_in;
  logic [PULSER_COUNT-1:0] phb_in;
  logic [PULSER_COUNT-1:0] pha_s1;
  logic [PULSER_COUNT-1:0] pha_s2;
  logic [PULSER_COUNT-1:0] phb_s1;
  logic [PULSER_COUNT-1:0] phb_s2;
  logic [PULSER_COUNT-1:0] single_lamp;
  logic [PULSER_COUNT-1:0] phase_a_lamp;
  logic [PULSER_COUNT-1:0] phase_b_lamp;

  sli_blink_gen #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_blink (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .blink_o   (blink)
  );

  assign pha_in = {pulser_three_phase_a_i, pulser_two_phase_a_i, pulser_one_phase_a_i};
  assign phb_in = {pulser_three_phase_b_i, pulser_two_phase_b_i, pulser_one_phase_b_i};

  // Network status lamp
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      status_lamp_o <= LAMP_RST;
    end else begin
      status_lamp_o <= net_established_i ? 1'b1 : blink;
    end
  end

  // Link detect synchroniser and lamp
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      link_s1     <= SYNC_RST;
      link_s2     <= SYNC_RST;
      link_lamp_o <= LAMP_RST;
    end else begin
      link_s1     <= link_connected_i;
      link_s2     <= link_s1;
      link_lamp_o <= link_s2;
    end
  end

  // Error lamp and halt request; error outranks warning
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      error_lamp_o <= LAMP_RST;
      halt_o       <= LAMP_RST;
    end else begin
      if (error_i) begin
        error_lamp_o <= 1'b1;
      end else if (warning_i) begin
        error_lamp_o <= blink;
      end else begin
        error_lamp_o <= 1'b0;
      end
      halt_o <= error_i;
    end
  end

  // Alarm lamp latches until reset
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      alarm_lamp_o <= LAMP_RST;
    end else if (system_error_i) begin
      alarm_lamp_o <= 1'b1;
    end
  end

  // Per-pulser phase synchronisers and lamps
  for (genvar g = 0; g < PULSER_COUNT; g++) begin : g_pulser
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        pha_s1[g] <= SYNC_RST;
        pha_s2[g] <= SYNC_RST;
        phb_s1[g] <= SYNC_RST;
        phb_s2[g] <= SYNC_RST;
      end else begin
        pha_s1[g] <= pha_in[g];
        pha_s2[g] <= pha_s1[g];
        phb_s1[g] <= phb_in[g];
        phb_s2[g] <= phb_s1[g];
      end
    end

    // Mixed phases hold the previous lamp state
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        single_lamp[g] <= LAMP_RST;
      end else if (VARIANT != SLI_ONE_LAMP) begin
        single_lamp[g] <= 1'b0;
      end else if (pha_s2[g] && phb_s2[g]) begin
        single_lamp[g] <= 1'b1;
      end else if (!pha_s2[g] && !phb_s2[g]) begin
        single_lamp[g] <= 1'b0;
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        phase_a_lamp[g] <= LAMP_RST;
        phase_b_lamp[g] <= LAMP_RST;
      end else begin
        phase_a_lamp[g] <= (VARIANT == SLI_TWO_LAMP) && pha_s2[g];
        phase_b_lamp[g] <= (VARIANT == SLI_TWO_LAMP) && phb_s2[g];
      end
    end

    if (VARIANT == SLI_ONE_LAMP) begin : g_one_chk
      property p_pulser_both_on;
        @(posedge sys_clk_i) disable iff (srst_i || rst_q)
          (pha_s2[g] && phb_s2[g]) |=> single_lamp[g];
      endproperty
      a_pulser_both_on: assert property (p_pulser_both_on)
        else $error("Pulser lamp dark with both phases on");

      property p_pulser_both_off;
        @(posedge sys_clk_i) disable iff (srst_i || rst_q)
          (!pha_s2[g] && !phb_s2[g]) |=> !single_lamp[g];
      endproperty
      a_pulser_both_off: assert property (p_pulser_both_off)
        else $error("Pulser lamp lit with both phases off");
    end else begin : g_two_chk
      property p_phase_lamp;
        @(posedge sys_clk_i) disable iff (srst_i || rst_q)
          pha_in[g] [*4] |-> (phase_a_lamp[g] && !single_lamp[g]);
      endproperty
      a_phase_lamp: assert property (p_phase_lamp)
        else $error("Phase A lamp not following a steady phase input");
    end
  end

  assign pulser_one_lamp_o           = single_lamp[0];
  assign pulser_two_lamp_o           = single_lamp[1];
  assign pulser_three_lamp_o         = single_lamp[2];
  assign pulser_one_phase_a_lamp_o   = phase_a_lamp[0];
  assign pulser_one_phase_b_lamp_o   = phase_b_lamp[0];
  assign pulser_two_phase_a_lamp_o   = phase_a_lamp[1];
  assign pulser_two_phase_b_lamp_o   = phase_b_lamp[1];
  assign pulser_three_phase_a_lamp_o = phase_a_lamp[2];
  assign pulser_three_phase_b_lamp_o = phase_b_lamp[2];

  // Reset seen one edge late, so checks skip the edge that leaves reset
  always_ff @(posedge sys_clk_i) begin
    rst_q <= srst_i;
  end

  // Checks
  property p_status_steady;
    @(posedge sys_clk_i) disable iff (srst_i || rst_q)
      net_established_i |=> status_lamp_o;
  endproperty
  a_status_steady: assert property (p_status_steady)
    else $error("Status lamp not steady after establishment");

  property p_status_blink;
    @(posedge sys_clk_i) disable iff (srst_i || rst_q)
      !net_established_i |=> (status_lamp_o == $past(blink));
  endproperty
  a_status_blink: assert property (p_status_blink)
    else $error("Status lamp not blinking while pending");

  property p_link_follow;
    @(posedge sys_clk_i) disable iff (srst_i || rst_q)
      link_connected_i [*4] |-> link_lamp_o;
  endproperty
  a_link_follow: assert property (p_link_follow)
    else $error("Link lamp dark while connected");

  property p_link_dark;
    @(posedge sys_clk_i) disable iff (srst_i || rst_q)
      !link_connected_i [*4] |-> !link_lamp_o;
  endproperty
  a_link_dark: assert property (p_link_dark)
    else $error("Link lamp lit while disconnected");

  property p_warn_blink;
    @(posedge sys_clk_i) disable iff (srst_i || rst_q)
      (warning_i && !error_i) |=> (!halt_o && error_lamp_o == $past(blink));
  endproperty
  a_warn_blink: assert property (p_warn_blink)
    else $error("Warning did not blink or halted operation");

  property p_error_on;
    @(posedge sys_clk_i) disable iff (srst_i || rst_q)
      error_i |=> (error_lamp_o && halt_o);
  endproperty
  a_error_on: assert property (p_error_on)
    else $error("Error did not light lamp and halt");

  property p_error_dark;
    @(posedge sys_clk_i) disable iff (srst_i || rst_q)
      (!error_i && !warning_i) |=> (!error_lamp_o && !halt_o);
  endproperty
  a_error_dark: assert property (p_error_dark)
    else $error("Error lamp lit with nothing pending");

  property p_alarm_latch;
    @(posedge sys_clk_i) disable iff (srst_i || rst_q)
      system_error_i |=> alarm_lamp_o [*8];
  endproperty
  a_alarm_latch: assert property (p_alarm_latch)
    else $error("Alarm lamp not latched after system error");

endmodule // sli_status_led

/* File: sli_tb.sv */
// Self-checking testbench for the indicator lamp logic
`timescale 1ns/10ps
module tb;
  import sli_pkg::*;
  localparam int unsigned HALF = 4;
  logic        sys_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        net = 1'b0, link = 1'b0, warn = 1'b0, err = 1'b0, syserr = 1'b0, clr = 1'b1;
  logic [5:0]  ph = 6'h00;
  logic [13:0] a;
  logic [8:0]  b;
  logic [7:0]  st_tog, er_tog;
  int          mismatches = 0;
  int          total_checks = 0;
  logic [5:0]  pv [5] = '{6'h3f, 6'h15, 6'h00, 6'h2a, 6'h0f};
  logic [2:0]  pe [5] = '{3'h7, 3'h7, 3'h0, 3'h0, 3'h3};

  always #5 sys_clk_i = ~sys_clk_i;

  sli_status_led #(.VARIANT(SLI_ONE_LAMP), .HALF_CYCLES(HALF)) sli_status_led_i (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .net_established_i(net), .link_connected_i(link),
    .warning_i(warn), .error_i(err), .system_error_i(syserr),
    .pulser_one_phase_a_i(ph[0]), .pulser_one_phase_b_i(ph[1]), .pulser_two_phase_a_i(ph[2]),
    .pulser_two_phase_b_i(ph[3]), .pulser_three_phase_a_i(ph[4]), .pulser_three_phase_b_i(ph[5]),
    .status_lamp_o(a[0]), .link_lamp_o(a[1]), .error_lamp_o(a[2]), .alarm_lamp_o(a[3]), .halt_o(a[4]),
    .pulser_one_lamp_o(a[5]), .pulser_two_lamp_o(a[6]), .pulser_three_lamp_o(a[7]),
    .pulser_one_phase_a_lamp_o(a[8]), .pulser_one_phase_b_lamp_o(a[9]), .pulser_two_phase_a_lamp_o(a[10]),
    .pulser_two_phase_b_lamp_o(a[11]), .pulser_three_phase_a_lamp_o(a[12]), .pulser_three_phase_b_lamp_o(a[13]));

  sli_status_led #(.VARIANT(SLI_TWO_LAMP), .HALF_CYCLES(HALF)) sli_status_led_two_i (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .net_established_i(net), .link_connected_i(link),
    .warning_i(warn), .error_i(err), .system_error_i(syserr),
    .pulser_one_phase_a_i(ph[0]), .pulser_one_phase_b_i(ph[1]), .pulser_two_phase_a_i(ph[2]),
    .pulser_two_phase_b_i(ph[3]), .pulser_three_phase_a_i(ph[4]), .pulser_three_phase_b_i(ph[5]),
    .status_lamp_o(), .link_lamp_o(), .error_lamp_o(), .alarm_lamp_o(), .halt_o(),
    .pulser_one_lamp_o(b[6]), .pulser_two_lamp_o(b[7]), .pulser_three_lamp_o(b[8]),
    .pulser_one_phase_a_lamp_o(b[0]), .pulser_one_phase_b_lamp_o(b[1]), .pulser_two_phase_a_lamp_o(b[2]),
    .pulser_two_phase_b_lamp_o(b[3]), .pulser_three_phase_a_lamp_o(b[4]), .pulser_three_phase_b_lamp_o(b[5]));

  sli_lamp_watch sli_lamp_watch_i (.sys_clk_i(sys_clk_i), .clear_i(clr), .lamp_i(a[0]), .toggles_o(st_tog));
  sli_lamp_watch sli_lamp_watch_err_i (.sys_clk_i(sys_clk_i), .clear_i(clr), .lamp_i(a[2]), .toggles_o(er_tog));

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic watch(input int n);
    @(posedge sys_clk_i) clr <= 1'b1;
    @(posedge sys_clk_i) clr <= 1'b0;
    step(n);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset;
    @(posedge sys_clk_i) srst_i <= 1'b1;
    step(5);
    srst_i <= 1'b0;
    chk({9'h000, b, a}, 32'h0, "lamps dark in reset");
    step(2);
    chk({9'h000, b, a}, {31'h0, net}, "lamps after reset");
    $display("reset test done");
  endtask

  task automatic t_status;
    watch(20);
    chk(32'(st_tog >= 8'h03), 32'h1, "status blinks while pending");
    @(posedge sys_clk_i) net <= 1'b1;
    step(3);
    watch(20);
    chk(32'(st_tog), 32'h0, "status steady");
    chk(32'(a[0]), 32'h1, "status lit");
    $display("status test done");
  endtask

  task automatic t_link;
    @(posedge sys_clk_i) link <= 1'b1;
    step(5);
    chk(32'(a[1]), 32'h1, "link lit");
    link <= 1'b0;
    step(5);
    chk(32'(a[1]), 32'h0, "link dark");
    $display("link test done");
  endtask

  task automatic t_error;
    @(posedge sys_clk_i) warn <= 1'b1;
    watch(20);
    chk(32'(er_tog >= 8'h03), 32'h1, "error lamp blinks on warning");
    chk(32'(a[4]), 32'h0, "no halt on warning");
    err <= 1'b1;
    step(2);
    watch(20);
    chk(32'(er_tog), 32'h0, "error lamp steady");
    chk(32'(a[4:2]), 32'h5, "error lamp lit and halt");
    err <= 1'b0;
    warn <= 1'b0;
    step(2);
    chk(32'(a[4:2]), 32'h0, "error lamp dark");
    $display("error test done");
  endtask

  task automatic t_alarm;
    @(posedge sys_clk_i) syserr <= 1'b1;
    @(posedge sys_clk_i) syserr <= 1'b0;
    step(1);
    chk(32'(a[3]), 32'h1, "alarm set");
    step(30);
    chk(32'(a[3]), 32'h1, "alarm held");
    do_reset();
    chk(32'(a[3]), 32'h0, "alarm cleared by reset");
    $display("alarm test done");
  endtask

  task automatic t_pulser;
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk_i) ph <= pv[i];
      step(5);
      chk(32'(a[7:5]), 32'(pe[i]), "single lamp");
      chk(32'({a[13:8], b[8:6]}), 32'h0, "unused lamp set dark");
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk_i) ph <= 6'h01 << i;
      step(5);
      chk(32'(b[5:0]), 32'(6'h01 << i), "phase lamp");
    end
    ph <= 6'h00;
    step(5);
    chk(32'(b[5:0]), 32'h0, "phase lamps dark");
    $display("pulser test done");
  endtask

  initial begin
    step(100000);
    mismatches++;
    finish_test();
  end

  initial begin
    do_reset();
    t_status();
    t_link();
    t_error();
    t_alarm();
    t_pulser();
    finish_test();
  end
endmodule // tb
